// ---- hw/fan_valve_ctrl.sv ----
// Fan speed and valve actuator with an AHB-Lite register slave
`timescale 1ns/100ps
`default_nettype none
`include "fan_valve_defines.svh"

// Functional notes
// RULE1: Direct mode takes speed from received byte
// RULE2: Direct byte uses the automatic thresholds
// RULE3: Default thresholds 10, 40, 70 percent
// RULE4: One to three speeds, three contacts
// RULE5: Manual object leaves automatic, byte steers
// RULE6: Automatic object value one restores automatic
// RULE7: Automatic state reported as one bit
// RULE8: Limits applied after threshold decision only
// RULE9: Equal commands handled in arrival order
// RULE10: Thermal valves driven by pulse width
// RULE11: Drive polarity from normally open/closed
// RULE12: Valve position linear in control value
// RULE13: Opening range can be limited
// RULE14: Lower and upper control bands ignored
// RULE15: Heating and cooling curves held separately
// RULE16: Control byte 0..255 means 0..100 percent
// RULE17: Pulsed valve only fully open or closed
// RULE18: Open fraction of cycle equals control value
// RULE19: Value held per cycle, converted to time
// RULE20: Mid-cycle value waits; speed has hysteresis
module fan_valve_ctrl
  import fan_valve_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `TICK_CYCLES
) (
  input  wire logic        sys_clk_in,       // System clock, 125 MHz
  input  wire logic        rst_b_in,         // Async reset, active low
  input  wire logic        hsel_in,          // AHB slave select
  input  wire logic [31:0] haddr_in,         // AHB address
  input  wire logic [1:0]  htrans_in,        // AHB transfer type
  input  wire logic        hwrite_in,        // AHB write
  input  wire logic [2:0]  hsize_in,         // AHB size
  input  wire logic [31:0] hwdata_in,        // AHB write data
  input  wire logic        hready_in,        // AHB bus ready
  output logic [31:0]      hrdata_out,       // AHB read data
  output logic             hreadyout_out,    // AHB slave ready
  output logic             hresp_out,        // AHB response
  output logic [2:0]       fan_contact_out,  // Fan contacts, one per speed
  output logic             heat_valve_out,   // Heating valve relay
  output logic             cool_valve_out,   // Cooling valve relay
  output logic             auto_active_out   // Automatic fan control active
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic        addr_ok;
  logic        wr_pend;
  logic [7:0]  wr_addr;
  logic        auto_mode;
  logic [7:0]  direct_byte;
  logic [7:0]  heat_cv;
  logic [7:0]  cool_cv;
  logic [31:0] fan_thresh;
  logic [7:0]  fan_hyst;
  logic [5:0]  fan_cfg;
  logic [31:0] heat_curve;
  logic [31:0] cool_curve;
  logic [1:0]  valve_cfg;
  logic [31:0] mod_period;
  logic [31:0] tick_cnt;
  logic        tick;
  fan_speed_t  raw_speed;
  fan_speed_t  next_raw_speed;
  logic [7:0]  fan_input;
  logic [1:0]  raw_num;
  logic [1:0]  lim_lo;
  logic [1:0]  lim_hi;
  logic [1:0]  stages;
  logic [1:0]  ceil_num;
  logic [1:0]  final_num;
  logic [1:0]  valve_open;
  logic [1:0]  valve_drive;
  logic [7:0]  valve_pos [2];
  logic [7:0]  valve_cv [2];
  logic [31:0] valve_curve [2];
  logic [31:0] read_mux;
  logic        addr_phase;
  logic        wr_auto;
  logic        wr_manual;
  logic        wr_direct;
  logic        wr_heat_cv;
  logic        wr_cool_cv;
  logic        wr_hyst;
  logic        wr_thresh;
  logic        wr_fan_cfg;
  logic        wr_heat_crv;
  logic        wr_cool_crv;
  logic        wr_valve_cfg;
  logic        wr_period;
  logic [7:0]  fan_demand;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  function automatic logic [1:0] speed_num(input fan_speed_t s);
    case (s)
      FAN_OFF: speed_num = 2'h0;
      FAN_S1:  speed_num = 2'h1;
      FAN_S2:  speed_num = 2'h2;
      FAN_S3:  speed_num = 2'h3;
      default: speed_num = 2'h0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave, zero wait states, always OKAY

  assign hreadyout_out = 1'b1;
  assign hresp_out     = 1'b0;
  assign addr_phase    = hsel_in && htrans_in[1] && hready_in;
  assign addr_ok       = (haddr_in[31:8] == 24'h00_0000) && (haddr_in[1:0] == 2'h0);

  assign read_mux =
    hit(haddr_in[7:0], `OFS_AUTO_MODE)    ? {31'h0000_0000, auto_mode} :
    hit(haddr_in[7:0], `OFS_MANUAL_MODE)  ? {31'h0000_0000, ~auto_mode} :
    hit(haddr_in[7:0], `OFS_DIRECT_SPEED) ? {24'h00_0000, direct_byte} :
    hit(haddr_in[7:0], `OFS_HEAT_CV)      ? {24'h00_0000, heat_cv} :
    hit(haddr_in[7:0], `OFS_COOL_CV)      ? {24'h00_0000, cool_cv} :
    hit(haddr_in[7:0], `OFS_FAN_THRESH)   ? fan_thresh :
    hit(haddr_in[7:0], `OFS_FAN_HYST)     ? {24'h00_0000, fan_hyst} :
    hit(haddr_in[7:0], `OFS_FAN_CFG)      ? {26'h000_0000, fan_cfg} :
    hit(haddr_in[7:0], `OFS_HEAT_CURVE)   ? heat_curve :
    hit(haddr_in[7:0], `OFS_COOL_CURVE)   ? cool_curve :
    hit(haddr_in[7:0], `OFS_VALVE_CFG)    ? {30'h0000_0000, valve_cfg} :
    hit(haddr_in[7:0], `OFS_MOD_PERIOD)   ? mod_period :
    hit(haddr_in[7:0], `OFS_STATUS)       ? {valve_pos[1], valve_pos[0], 9'h000,
                                             valve_open, final_num, raw_num, auto_mode} :
                                            32'h0000_0000;

  // Address phase is captured; the write lands in the following data phase
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wr_pend    <= 1'b0;
      wr_addr    <= 8'h00;
      hrdata_out <= 32'h0000_0000;
    end else begin
      wr_pend    <= addr_phase && hwrite_in && addr_ok;
      wr_addr    <= haddr_in[7:0];
      hrdata_out <= (addr_phase && !hwrite_in && addr_ok) ? read_mux : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file, one write per data phase in bus order

  assign wr_auto   = wr_pend && hit(wr_addr, `OFS_AUTO_MODE);
  assign wr_manual = wr_pend && hit(wr_addr, `OFS_MANUAL_MODE);

  // Write strobes, one per register
  assign wr_direct    = wr_pend && hit(wr_addr, `OFS_DIRECT_SPEED);
  assign wr_heat_cv   = wr_pend && hit(wr_addr, `OFS_HEAT_CV);
  assign wr_cool_cv   = wr_pend && hit(wr_addr, `OFS_COOL_CV);
  assign wr_hyst      = wr_pend && hit(wr_addr, `OFS_FAN_HYST);
  assign wr_thresh    = wr_pend && hit(wr_addr, `OFS_FAN_THRESH);
  assign wr_fan_cfg   = wr_pend && hit(wr_addr, `OFS_FAN_CFG);
  assign wr_heat_crv  = wr_pend && hit(wr_addr, `OFS_HEAT_CURVE);
  assign wr_cool_crv  = wr_pend && hit(wr_addr, `OFS_COOL_CURVE);
  assign wr_valve_cfg = wr_pend && hit(wr_addr, `OFS_VALVE_CFG);
  assign wr_period    = wr_pend && hit(wr_addr, `OFS_MOD_PERIOD);

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      auto_mode <= 1'b1;
    end else if (wr_auto) begin
      auto_mode <= hwdata_in[0];                                  // see RULE6 RULE9
    end else if (wr_manual && hwdata_in[0]) begin
      auto_mode <= 1'b0;                                          // see RULE5
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      direct_byte <= 8'h00;
      heat_cv     <= 8'h00;
      cool_cv     <= 8'h00;
      fan_hyst    <= `RST_FAN_HYST;
      fan_thresh  <= `RST_FAN_THRESH;                             // see RULE3
      fan_cfg     <= `RST_FAN_CFG;
    end else if (wr_pend) begin
      if (wr_direct) begin
        direct_byte <= hwdata_in[7:0];                            // see RULE1
      end
      if (wr_heat_cv) begin
        heat_cv <= hwdata_in[7:0];
      end
      if (wr_cool_cv) begin
        cool_cv <= hwdata_in[7:0];
      end
      if (wr_hyst) begin
        fan_hyst <= hwdata_in[7:0];
      end
      if (wr_thresh) begin
        fan_thresh <= hwdata_in;
      end
      if (wr_fan_cfg) begin
        fan_cfg <= hwdata_in[5:0];
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      heat_curve <= `RST_CURVE;
      cool_curve <= `RST_CURVE;
      valve_cfg  <= `RST_VALVE_CFG;
      mod_period <= `MOD_PERIOD_TICKS;
    end else if (wr_pend) begin
      if (wr_heat_crv) begin
        heat_curve <= hwdata_in;                                  // see RULE15
      end
      if (wr_cool_crv) begin
        cool_curve <= hwdata_in;                                  // see RULE15
      end
      if (wr_valve_cfg) begin
        valve_cfg <= hwdata_in[1:0];
      end
      if (wr_period) begin
        mod_period <= hwdata_in;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fan speed by thresholds with hysteresis

  // Automatic mode follows the larger demand of heating and cooling
  assign fan_demand = (heat_cv > cool_cv) ? heat_cv : cool_cv;
  assign fan_input  = auto_mode ? fan_demand : direct_byte;       // see RULE1 RULE5

  // Steps one speed per cycle; up at a threshold, down below it minus hysteresis
  always_comb begin
    next_raw_speed = raw_speed;
    case (raw_speed)                                              // see RULE2 RULE20
      FAN_OFF: begin
        if (fan_input >= fan_thresh[7:0]) begin
          next_raw_speed = FAN_S1;
        end
      end
      FAN_S1: begin
        if (fan_input >= fan_thresh[15:8]) begin
          next_raw_speed = FAN_S2;
        end else if ({1'b0, fan_input} + {1'b0, fan_hyst} < {1'b0, fan_thresh[7:0]}) begin
          next_raw_speed = FAN_OFF;
        end
      end
      FAN_S2: begin
        if (fan_input >= fan_thresh[23:16]) begin
          next_raw_speed = FAN_S3;
        end else if ({1'b0, fan_input} + {1'b0, fan_hyst} < {1'b0, fan_thresh[15:8]}) begin
          next_raw_speed = FAN_S1;
        end
      end
      FAN_S3: begin
        if ({1'b0, fan_input} + {1'b0, fan_hyst} < {1'b0, fan_thresh[23:16]}) begin
          next_raw_speed = FAN_S2;
        end
      end
      default: next_raw_speed = FAN_OFF;
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      raw_speed <= FAN_OFF;
    end else begin
      raw_speed <= next_raw_speed;
    end
  end

  // Limits act on the chosen speed only, never on the threshold state
  assign raw_num   = speed_num(raw_speed);
  assign stages    = (fan_cfg[`FLD_CFG_STAGES] == 2'h0) ? 2'h1 : fan_cfg[`FLD_CFG_STAGES];
  assign lim_lo    = fan_cfg[`FLD_CFG_LIM_MIN];
  assign lim_hi    = fan_cfg[`FLD_CFG_LIM_MAX];
  assign ceil_num  = (lim_hi < stages) ? lim_hi : stages;
  assign final_num = (raw_num < lim_lo) ? ((lim_lo < ceil_num) ? lim_lo : ceil_num) :
                     (raw_num > ceil_num) ? ceil_num : raw_num;   // see RULE8 RULE4

  // One contact closed per speed, all open when off
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      fan_contact_out <= 3'h0;
      auto_active_out <= 1'b0;
    end else begin
      fan_contact_out <= {final_num == 2'h3, final_num == 2'h2, final_num == 2'h1}; // see RULE4
      auto_active_out <= auto_mode;                               // see RULE7
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Modulation time base

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tick_cnt <= 32'h0000_0000;
      tick     <= 1'b0;
    end else if (tick_cnt >= TICK_CYCLES - 1) begin
      tick_cnt <= 32'h0000_0000;
      tick     <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 32'h0000_0001;
      tick     <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Heating (0) and cooling (1) valve channels

  assign valve_cv[0]    = heat_cv;
  assign valve_cv[1]    = cool_cv;
  assign valve_curve[0] = heat_curve;
  assign valve_curve[1] = cool_curve;

  for (genvar ch = 0; ch < 2; ch++) begin : g_valve
    valve_channel u_valve (                                       // see RULE15
      .sys_clk_in   (sys_clk_in),
      .rst_b_in     (rst_b_in),
      .cv_in        (valve_cv[ch]),
      .curve_in     (valve_curve[ch]),
      .norm_open_in (valve_cfg[ch]),
      .period_in    (mod_period),
      .tick_in      (tick),
      .drive_out    (valve_drive[ch]),
      .open_out     (valve_open[ch]),
      .pos_out      (valve_pos[ch])
    );
  end

  assign heat_valve_out = valve_drive[0];
  assign cool_valve_out = valve_drive[1];

endmodule // fan_valve_ctrl

`default_nettype wire

// ---- hw/fan_valve_defines.svh ----
// Register offsets, field positions, reset values and timing counts
`ifndef FAN_VALVE_DEFINES_SVH
`define FAN_VALVE_DEFINES_SVH

`define OFS_AUTO_MODE     8'h00
`define OFS_MANUAL_MODE   8'h04
`define OFS_DIRECT_SPEED  8'h08
`define OFS_HEAT_CV       8'h0C
`define OFS_COOL_CV       8'h10
`define OFS_FAN_THRESH    8'h14
`define OFS_FAN_HYST      8'h18
`define OFS_FAN_CFG       8'h1C
`define OFS_HEAT_CURVE    8'h20
`define OFS_COOL_CURVE    8'h24
`define OFS_VALVE_CFG     8'h28
`define OFS_MOD_PERIOD    8'h2C
`define OFS_STATUS        8'h30

`define FLD_CFG_STAGES    1:0
`define FLD_CFG_LIM_MIN   3:2
`define FLD_CFG_LIM_MAX   5:4
`define FLD_CURVE_VMIN    7:0
`define FLD_CURVE_VMAX    15:8
`define FLD_CURVE_CV_LOW  23:16
`define FLD_CURVE_CV_HIGH 31:24

// Thresholds 10 %, 40 %, 70 % of 255, rounded up
`define RST_FAN_THRESH    32'h00B3661A
`define RST_FAN_HYST      8'h00
`define RST_FAN_CFG       6'h33
`define RST_CURVE         32'hFF00FF00
`define RST_VALVE_CFG     2'h0

`define CLK_PERIOD_NS     8
`define TICK_TIME_NS      1000000
`define TICK_CYCLES       (`TICK_TIME_NS / `CLK_PERIOD_NS)
`define MOD_PERIOD_MIN    15
`define MOD_PERIOD_TICKS  (`MOD_PERIOD_MIN * 60 * (1000000000 / `TICK_TIME_NS))

`endif

// ---- hw/fan_valve_pkg.sv ----
// Types shared by the fan and valve control logic
package fan_valve_pkg;

  // Fan speed, Gray coded along the up/down path
  typedef enum logic [1:0] {
    FAN_OFF = 2'b00,
    FAN_S1  = 2'b01,
    FAN_S2  = 2'b11,
    FAN_S3  = 2'b10
  } fan_speed_t;

endpackage

// ---- hw/valve_channel.sv ----
// One valve output: curve adaptation and pulse width modulation
`timescale 1ns/100ps
`default_nettype none
`include "fan_valve_defines.svh"

module valve_channel (
  input  wire logic        sys_clk_in,    // System clock
  input  wire logic        rst_b_in,      // Async reset, active low
  input  wire logic [7:0]  cv_in,         // Control value 0..255
  input  wire logic [31:0] curve_in,      // Band and range limits
  input  wire logic        norm_open_in,  // Drive opens when de-energised
  input  wire logic [31:0] period_in,     // Modulation period in ticks
  input  wire logic        tick_in,       // One-cycle time base pulse
  output logic             drive_out,     // Relay drive to the valve
  output logic             open_out,      // Valve commanded open
  output logic [7:0]       pos_out        // Position latched for this cycle
);

  logic [7:0]  vmin;
  logic [7:0]  vmax;
  logic [7:0]  span;
  logic [7:0]  eff_cv;
  logic [8:0]  eff9;
  logic [16:0] scaled;
  logic [7:0]  next_pos;
  logic [8:0]  pos9;
  logic [40:0] on_prod;
  logic [31:0] last_tick;
  logic        cycle_end;
  logic [31:0] cyc_cnt;
  logic [31:0] on_ticks;

  assign vmin   = curve_in[`FLD_CURVE_VMIN];
  assign vmax   = curve_in[`FLD_CURVE_VMAX];
  assign span   = (vmax > vmin) ? (vmax - vmin) : 8'h00;                 // see RULE13
  // Inside the lower band the valve goes to vmin, inside the upper band to vmax
  assign eff_cv = (cv_in <= curve_in[`FLD_CURVE_CV_LOW])  ? 8'h00 :      // see RULE14
                  (cv_in >= curve_in[`FLD_CURVE_CV_HIGH]) ? 8'hFF : cv_in;
  assign eff9   = {1'b0, eff_cv} + {8'h00, eff_cv[7]};                   // see RULE16
  assign scaled = span * eff9;                                           // see RULE12
  assign next_pos = vmin + scaled[15:8];
  assign pos9   = {1'b0, next_pos} + {8'h00, next_pos[7]};
  assign on_prod   = period_in * pos9;                                   // see RULE18
  assign last_tick = (period_in == 32'h0000_0000) ? 32'h0000_0000 : period_in - 32'h0000_0001;
  assign cycle_end = tick_in && (cyc_cnt >= last_tick);

  // Value is frozen for a whole cycle and only taken at the cycle boundary
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cyc_cnt  <= 32'h0000_0000;
      on_ticks <= 32'h0000_0000;
      pos_out  <= 8'h00;
    end else if (cycle_end) begin
      cyc_cnt  <= 32'h0000_0000;
      pos_out  <= next_pos;                                              // see RULE20
      on_ticks <= on_prod[39:8];                                         // see RULE19
    end else if (tick_in) begin
      cyc_cnt  <= cyc_cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      open_out  <= 1'b0;
      drive_out <= 1'b0;
    end else begin
      open_out  <= (cyc_cnt < on_ticks);                                 // see RULE17
      drive_out <= (cyc_cnt < on_ticks) ^ norm_open_in;                  // see RULE11 RULE10
    end
  end

endmodule // valve_channel

`default_nettype wire

// ---- verif/fan_valve_chk.sv ----
// Port checker for the fan and valve controller, bound to its top
`timescale 1ns/100ps
`default_nettype none
`include "fan_valve_defines.svh"

module fan_valve_chk
  import fan_valve_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = 2
) (
  input wire logic        sys_clk_in,       // Clock
  input wire logic        rst_b_in,         // Reset, active low
  input wire logic        hsel_in,          // Select
  input wire logic [31:0] haddr_in,         // Address
  input wire logic [1:0]  htrans_in,        // Transfer type
  input wire logic        hwrite_in,        // Write
  input wire logic [31:0] hwdata_in,        // Write data
  input wire logic        hready_in,        // Bus ready
  input wire logic [31:0] hrdata_out,       // Read data
  input wire logic        hreadyout_out,    // Slave ready
  input wire logic        hresp_out,        // Response
  input wire logic [2:0]  fan_contact_out,  // Fan contacts
  input wire logic        auto_active_out   // Automatic active
);
  logic        d_act;
  logic        d_wr;
  logic [31:0] d_addr;

  // Data phase tracker
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      d_act  <= 1'b0;
      d_wr   <= 1'b0;
      d_addr <= 32'h00000000;
    end else if (hready_in) begin
      d_act  <= hsel_in & htrans_in[1];
      d_wr   <= hwrite_in;
      d_addr <= haddr_in;
    end
  end

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);

  ////////////////////////////////////////////////////////////////////////////////
  sequence auto_set_s;
    d_act && d_wr && d_addr == 32'(`OFS_AUTO_MODE) && hwdata_in[0];
  endsequence
  sequence manual_set_s;
    d_act && d_wr && ((d_addr == 32'(`OFS_MANUAL_MODE) && hwdata_in[0]) ||
                      (d_addr == 32'(`OFS_AUTO_MODE) && !hwdata_in[0]));
  endsequence

  ready_const_a: assert property (hreadyout_out) else $error("slave stalled");
  resp_okay_a: assert property (!hresp_out) else $error("error response");
  contact_onehot_a: assert property ($onehot0(fan_contact_out))
    else $error("more than one fan contact closed");
  auto_enter_a: assert property (auto_set_s |-> ##[1:3] auto_active_out)
    else $error("automatic not entered");
  manual_enter_a: assert property (manual_set_s |-> ##[1:3] !auto_active_out)
    else $error("manual not entered");
  unmapped_zero_a: assert property (d_act && !d_wr && d_addr >= 32'h00000100
    |-> hrdata_out == 32'h00000000) else $error("unmapped read not zero");
  mode_upper_a: assert property (d_act && !d_wr && d_addr == 32'(`OFS_AUTO_MODE)
    |-> hrdata_out[31:1] == 31'h00000000) else $error("mode read upper bits set");
  rdata_idle_a: assert property (!(d_act && !d_wr) |-> hrdata_out == 32'h00000000)
    else $error("read data outside data phase");
  reset_auto_a: assert property ($rose(rst_b_in) |-> ##[0:2] auto_active_out)
    else $error("automatic not active after reset");
endmodule // fan_valve_chk

bind fan_valve_ctrl fan_valve_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .sys_clk_in, .rst_b_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in, .hwdata_in,
  .hready_in, .hrdata_out, .hreadyout_out, .hresp_out, .fan_contact_out, .auto_active_out
);
`default_nettype wire

// ---- verif/thermostat_model.sv ----
// Bus master standing in for the thermostat that sends control values
`timescale 1ns/100ps
`default_nettype none

module thermostat_model (
  input  wire logic        sys_clk_in,  // Clock
  input  wire logic        hready_in,   // Bus ready
  input  wire logic [31:0] hrdata_in,   // Read data
  output var logic         hsel_out,    // Select
  output var logic [31:0]  haddr_out,   // Address
  output var logic [1:0]   htrans_out,  // Transfer type
  output var logic         hwrite_out,  // Write
  output var logic [2:0]   hsize_out,   // Size
  output var logic [31:0]  hwdata_out   // Write data
);
  initial begin
    hsel_out   = 1'b0;
    haddr_out  = 32'h00000000;
    htrans_out = 2'b00;
    hwrite_out = 1'b0;
    hsize_out  = 3'h2;
    hwdata_out = 32'h00000000;
  end

  // One single word transfer; released address and data lines show the inverse of their last value
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge sys_clk_in);
    hsel_out   <= 1'b1;
    haddr_out  <= a;
    htrans_out <= 2'b10;
    hwrite_out <= w;
    do @(posedge sys_clk_in); while (hready_in !== 1'b1);
    hsel_out   <= 1'b0;
    htrans_out <= 2'b00;
    haddr_out  <= ~a;
    hwdata_out <= w ? d : ~hwdata_out;
    do @(posedge sys_clk_in); while (hready_in !== 1'b1);
    q = hrdata_in;
    hwdata_out <= w ? ~d : hwdata_out;
  endtask
endmodule // thermostat_model
`default_nettype wire

// ---- verif/tb_top.sv ----
// Self-checking bench for the fan and valve controller
`timescale 1ns/100ps
`default_nettype none
`include "fan_valve_defines.svh"

module tb_top
  import fan_valve_pkg::*;
;
  localparam int TICKS = 2;
  localparam int PER   = 8;
  localparam int WIN   = 2 * PER * TICKS;

  logic        sys_clk_in;
  logic        rst_b_in;
  logic        hsel_in;
  logic [31:0] haddr_in;
  logic [1:0]  htrans_in;
  logic        hwrite_in;
  logic [2:0]  hsize_in;
  logic [31:0] hwdata_in;
  logic [31:0] hrdata_out;
  logic        hreadyout_out;
  logic        hresp_out;
  logic [2:0]  fan_contact_out;
  logic        heat_valve_out;
  logic        cool_valve_out;
  logic        auto_active_out;
  int          miscompares = 0;
  int          n_compared = 0;
  int          cycles = 0;

  fan_valve_ctrl #(.TICK_CYCLES(TICKS)) u_dut (
    .sys_clk_in, .rst_b_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in, .hsize_in,
    .hwdata_in, .hready_in(hreadyout_out), .hrdata_out, .hreadyout_out, .hresp_out,
    .fan_contact_out, .heat_valve_out, .cool_valve_out, .auto_active_out
  );
  thermostat_model u_master (
    .sys_clk_in, .hready_in(hreadyout_out), .hrdata_in(hrdata_out), .hsel_out(hsel_in),
    .haddr_out(haddr_in), .htrans_out(htrans_in), .hwrite_out(hwrite_in),
    .hsize_out(hsize_in), .hwdata_out(hwdata_in)
  );

  initial begin
    sys_clk_in = 1'b0;
    forever #4 sys_clk_in = ~sys_clk_in;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check_val(string n, logic [31:0] e, logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic check_count(string n, int e, int g);
    n_compared++;
    if (g != e) begin
      miscompares++;
      $display("[FAIL] %s expected %0d seen %0d", n, e, g);
    end
  endtask
  task automatic wr(logic [31:0] a, logic [31:0] d);
    logic [31:0] q;
    u_master.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(logic [31:0] a, output logic [31:0] q);
    u_master.xfer(1'b0, a, 32'h00000000, q);
  endtask
  // Speed state steps once a clock, contacts one clock later
  task automatic fan_step(logic [7:0] b, logic [2:0] e);
    wr(32'(`OFS_DIRECT_SPEED), {24'h000000, b});
    repeat (8) @(negedge sys_clk_in);
    check_val("fan contacts", {29'h0, e}, {29'h0, fan_contact_out});
  endtask

  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      close_out();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  logic [31:0] r_addr [5] = '{32'h00, 32'h14, 32'h18, 32'h20, 32'h100};
  logic [31:0] r_exp  [5] = '{32'h1, 32'h00B3661A, 32'h0, 32'hFF00FF00, 32'h0};
  logic [7:0]  f_byte [9] = '{8'd0, 8'd25, 8'd26, 8'd101, 8'd102, 8'd178, 8'd179, 8'd255, 8'd0};
  logic [2:0]  f_exp  [9] = '{3'h0, 3'h0, 3'h1, 3'h1, 3'h2, 3'h2, 3'h4, 3'h4, 3'h0};
  logic [31:0] v_curve [5] = '{32'hFF00FF00, 32'hFF00FF00, 32'hFF00FF00, 32'hFF007F00,
                               32'hFF64FF00};
  logic [1:0]  v_cfg  [5] = '{2'h0, 2'h0, 2'h3, 2'h0, 2'h0};
  logic [7:0]  v_heat [5] = '{8'd0, 8'd128, 8'd0, 8'd255, 8'd90};
  logic [7:0]  v_cool [5] = '{8'd255, 8'd64, 8'd0, 8'd255, 8'd0};
  int          v_eh   [5] = '{0, 4, 8, 3, 0};
  int          v_ec   [5] = '{8, 1, 8, 8, 0};

  initial begin
    logic [31:0] q;
    int h;
    int c;
    rst_b_in = 1'b0;
    repeat (3) @(posedge sys_clk_in);
    rst_b_in <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      rd(r_addr[i], q);
      check_val("reset value", r_exp[i], q);
    end
    $display("test reset values done");
    wr(32'(`OFS_MOD_PERIOD), PER);
    wr(32'(`OFS_FAN_CFG), 32'h33);
    wr(32'(`OFS_MANUAL_MODE), 32'h1);
    repeat (2) @(negedge sys_clk_in);
    check_val("auto flag", 32'h0, {31'h0, auto_active_out});
    for (int i = 0; i < 9; i++) fan_step(f_byte[i], f_exp[i]);
    $display("test direct speed rows done");
    wr(32'(`OFS_FAN_HYST), 32'd20);
    fan_step(8'd30, 3'h1);
    fan_step(8'd10, 3'h1);
    fan_step(8'd5, 3'h0);
    wr(32'(`OFS_FAN_CFG), 32'h13);
    fan_step(8'd255, 3'h1);
    wr(32'(`OFS_FAN_CFG), 32'h33);
    fan_step(8'd255, 3'h4);
    wr(32'(`OFS_FAN_CFG), 32'h3B);
    fan_step(8'd0, 3'h2);
    wr(32'(`OFS_FAN_CFG), 32'h33);
    wr(32'(`OFS_DIRECT_SPEED), 32'd255);
    fan_step(8'd0, 3'h0);
    $display("test hysteresis, limits and order done");
    wr(32'(`OFS_COOL_CV), 32'd200);
    wr(32'(`OFS_AUTO_MODE), 32'h1);
    fan_step(8'd0, 3'h4);
    check_val("auto flag", 32'h1, {31'h0, auto_active_out});
    rd(32'(`OFS_AUTO_MODE), q);
    check_val("mode read", 32'h1, q);
    wr(32'(`OFS_AUTO_MODE), 32'h0);
    fan_step(8'd0, 3'h0);
    check_val("auto flag", 32'h0, {31'h0, auto_active_out});
    $display("test mode switching done");
    for (int i = 0; i < 5; i++) begin
      wr(32'(`OFS_HEAT_CURVE), v_curve[i]);
      wr(32'(`OFS_VALVE_CFG), {30'h0, v_cfg[i]});
      wr(32'(`OFS_HEAT_CV), {24'h000000, v_heat[i]});
      wr(32'(`OFS_COOL_CV), {24'h000000, v_cool[i]});
      repeat (2 * PER * TICKS) @(negedge sys_clk_in);
      h = 0;
      c = 0;
      repeat (WIN) begin
        @(negedge sys_clk_in);
        h += (heat_valve_out === 1'b1) ? 1 : 0;
        c += (cool_valve_out === 1'b1) ? 1 : 0;
      end
      check_count("heat on time", v_eh[i] * 2 * TICKS, h);
      check_count("cool on time", v_ec[i] * 2 * TICKS, c);
    end
    $display("test valve rows done");
    close_out();
  end
endmodule // tb_top
`default_nettype wire
